/* File: hw/dwn_control.sv */
/*
 * command interpreter for a two-channel 256-position wiper with
 * nonvolatile backups, user bytes and one-way write protection that only reset clears.
 * assumes a deserialised command port synchronous to core_clk_in;
 * the serial framing lives outside this block.
 */
// What this block does
// - two independent wiper registers, each selecting one of 256 positions
// - load command writes any value into the chosen channel's wiper
// - restore copies a channel's backup into its wiper
// - save copies a channel's wiper into its backup
// - at power-on an internal preset strobe loads wipers from backups
// - external preset strobe does the same backup to wiper transfer
// - every wiper, backup and user byte can be read back
// - fourteen general-purpose nonvolatile bytes, writable and readable
// - increment or decrement moves a wiper by exactly one position, holding at the top and bottom ends
// - left or right shift doubles (saturating at full scale) or halves a wiper value
// - once protection is set, nonvolatile contents refuse changes
`default_nettype none
`timescale 1ns/1ps

module dwn_control #(
    parameter int unsigned W          = dwn_pkg::DATA_W,
    parameter int unsigned USER_BYTES = dwn_pkg::USER_BYTES
) (
    // clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_n_in,
    // command port
    input  wire logic                  cmd_valid_in,
    input  wire dwn_pkg::dwn_cmd_t     cmd_in,
    input  wire logic                  cmd_ch_in,
    input  wire logic [1:0]            rd_kind_in,
    input  wire logic [dwn_pkg::SEL_W-1:0] cmd_addr_in,
    input  wire logic [W-1:0]          cmd_data_in,
    // preset strobe from outside, active low
    input  wire logic                  preset_n_in,
    // wiper positions
    output logic      [W-1:0]          wiper_setting_ch1_out,
    output logic      [W-1:0]          wiper_setting_ch2_out,
    // read answer
    output logic                       rd_valid_out,
    output logic      [W-1:0]          rd_data_out,
    // status
    output logic                       protected_out,
    output logic                       refused_out,
    output logic                       busy_out
);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {
        DWN_ST_POWERUP,
        DWN_ST_IDLE
    } dwn_state_t;

    dwn_state_t   state_ff;
    logic [7:0]   por_cnt_ff;
    logic [W-1:0] wiper_setting_reg_ff [2];
    logic [W-1:0] nv_wiper_backup_ff   [2];
    logic         protect_ff;
    logic         preset_q_ff;
    logic         rd_valid_ff;
    logic [W-1:0] rd_data_ff;
    logic         refused_ff;
    logic         busy_ff;
    logic [W-1:0] step_result;
    logic [W-1:0] user_rd_data;
    logic         preset_fire;
    logic         cmd_take;
    logic         user_wr;
    logic         nv_write_cmd;

    // ************************************************************
    // command decode
    // ************************************************************

    // commands are ignored while the power-on transfer is pending
    assign cmd_take = cmd_valid_in && state_ff == DWN_ST_IDLE;

    // external strobe acts on its falling edge so a held-low pin fires once
    assign preset_fire = (state_ff == DWN_ST_POWERUP &&
                          por_cnt_ff == 8'(dwn_pkg::PRESET_CYCLES))
                         || (preset_q_ff && !preset_n_in
                             && state_ff == DWN_ST_IDLE);

    // true for every command that writes the nonvolatile store (save and user write)
    function automatic logic is_nv_write(input dwn_pkg::dwn_cmd_t c);
        return c == dwn_pkg::DWN_CMD_SAVE || c == dwn_pkg::DWN_CMD_USER_WR;
    endfunction

    assign nv_write_cmd = cmd_take && is_nv_write(cmd_in);
    assign user_wr = nv_write_cmd && !protect_ff
                     && cmd_in == dwn_pkg::DWN_CMD_USER_WR;

    // ************************************************************
    // submodules
    // ************************************************************
    dwn_wiper_step #(
        .W          (W)
    ) u_step (
        .value_in   (wiper_setting_reg_ff[cmd_ch_in]),
        .cmd_in     (cmd_in),
        .result_out (step_result)
    );

    dwn_user_store #(
        .DEPTH       (USER_BYTES),
        .W           (W),
        .AW          (dwn_pkg::SEL_W)
    ) u_user (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .wr_en_in    (user_wr),
        .wr_addr_in  (cmd_addr_in),
        .wr_data_in  (cmd_data_in),
        .rd_addr_in  (cmd_addr_in),
        .rd_data_out (user_rd_data)
    );

    // ************************************************************
    // power-on sequencing
    // ************************************************************

    // short wait after reset so the store settles before the preset
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff   <= DWN_ST_POWERUP;
            busy_ff    <= 1'b1;
            por_cnt_ff <= 8'h00;
        end else if (state_ff == DWN_ST_POWERUP) begin
            if (por_cnt_ff == 8'(dwn_pkg::PRESET_CYCLES)) begin
                state_ff <= DWN_ST_IDLE;
                busy_ff  <= 1'b0;
            end else begin
                por_cnt_ff <= por_cnt_ff + 8'h01;
            end
        end
    end

    // previous level of the strobe pin for edge detection
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            preset_q_ff <= 1'b1;
        end else begin
            preset_q_ff <= preset_n_in;
        end
    end

    // ************************************************************
    // wiper registers
    // ************************************************************

    // preset outranks any wiper command in the same cycle; a save still writes the backup
    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_wiper
            always_ff @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    wiper_setting_reg_ff[gc] <= dwn_pkg::WIPER_RST;
                end else if (preset_fire) begin
                    wiper_setting_reg_ff[gc] <= nv_wiper_backup_ff[gc];
                end else if (cmd_take && cmd_ch_in == 1'(gc)) begin
                    unique case (cmd_in)
                        dwn_pkg::DWN_CMD_LOAD: begin
                            wiper_setting_reg_ff[gc] <= cmd_data_in;
                        end
                        dwn_pkg::DWN_CMD_RESTORE: begin
                            wiper_setting_reg_ff[gc] <= nv_wiper_backup_ff[gc];
                        end
                        dwn_pkg::DWN_CMD_INC,
                        dwn_pkg::DWN_CMD_DEC,
                        dwn_pkg::DWN_CMD_SHL,
                        dwn_pkg::DWN_CMD_SHR: begin
                            wiper_setting_reg_ff[gc] <= step_result;
                        end
                        default: begin
                        end
                    endcase
                end
            end

            // backup only changes on an unprotected save
            always_ff @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    nv_wiper_backup_ff[gc] <= dwn_pkg::BACKUP_RST;
                end else if (cmd_take && cmd_ch_in == 1'(gc)
                             && cmd_in == dwn_pkg::DWN_CMD_SAVE
                             && !protect_ff) begin
                    nv_wiper_backup_ff[gc] <= wiper_setting_reg_ff[gc];
                end
            end
        end
    endgenerate

    // ************************************************************
    // protection
    // ************************************************************

    // one-way latch: only reset clears it, standing in for a fuse
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            protect_ff <= 1'b0;
        end else if (cmd_take && cmd_in == dwn_pkg::DWN_CMD_PROTECT) begin
            protect_ff <= 1'b1;
        end
    end

    // refused pulses for one cycle after a blocked write
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            refused_ff <= 1'b0;
        end else begin
            refused_ff <= nv_write_cmd && protect_ff;
        end
    end

    // ************************************************************
    // readback
    // ************************************************************

    // answer one cycle after the read command
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_valid_ff <= 1'b0;
            rd_data_ff  <= '0;
        end else begin
            rd_valid_ff <= cmd_take && cmd_in == dwn_pkg::DWN_CMD_READ;
            if (cmd_take && cmd_in == dwn_pkg::DWN_CMD_READ) begin
                unique case (rd_kind_in)
                    dwn_pkg::RD_WIPER: begin
                        rd_data_ff <= wiper_setting_reg_ff[cmd_ch_in];
                    end
                    dwn_pkg::RD_BACKUP: begin
                        rd_data_ff <= nv_wiper_backup_ff[cmd_ch_in];
                    end
                    dwn_pkg::RD_USER: begin
                        rd_data_ff <= user_rd_data;
                    end
                    default: begin
                        rd_data_ff <= '0;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // outputs, all straight from flops
    // ************************************************************
    assign wiper_setting_ch1_out = wiper_setting_reg_ff[0];
    assign wiper_setting_ch2_out = wiper_setting_reg_ff[1];
    assign rd_valid_out          = rd_valid_ff;
    assign rd_data_out           = rd_data_ff;
    assign protected_out         = protect_ff;
    assign refused_out           = refused_ff;
    assign busy_out              = busy_ff;

endmodule

`default_nettype wire

/* File: hw/dwn_user_store.sv */
/*
 * general-purpose nonvolatile byte array with write and read ports.
 * assumes writes are already qualified by the write-protect state.
 */
`default_nettype none
`timescale 1ns/1ps

module dwn_user_store #(
    parameter int unsigned DEPTH = 14,
    parameter int unsigned W     = 8,
    parameter int unsigned AW    = 4
) (
    // clock and reset
    input  wire logic          core_clk_in,
    input  wire logic          rst_n_in,
    // write port
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [W-1:0]  wr_data_in,
    // read port
    input  wire logic [AW-1:0] rd_addr_in,
    output logic      [W-1:0]  rd_data_out
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [W-1:0] mem_ff [DEPTH];

    // one flop per byte so reset gives a known blank store
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_byte
            always_ff @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    mem_ff[gi] <= dwn_pkg::USER_RST;
                end else if (wr_en_in && wr_addr_in == AW'(gi)) begin
                    mem_ff[gi] <= wr_data_in;
                end
            end
        end
    endgenerate

    // out-of-range addresses read as zero
    always_comb begin
        rd_data_out = '0;
        if (rd_addr_in < AW'(DEPTH)) begin
            rd_data_out = mem_ff[rd_addr_in];
        end
    end

endmodule

`default_nettype wire

/* File: hw/dwn_wiper_step.sv */
/*
 * combinational step and shift of one wiper value, saturating at the ends.
 * assumes the caller picks the command and registers the result.
 */
`default_nettype none
`timescale 1ns/1ps

module dwn_wiper_step #(
    parameter int unsigned W = 8
) (
    // operands
    input  wire logic [W-1:0] value_in,
    input  wire dwn_pkg::dwn_cmd_t cmd_in,
    // result
    output logic      [W-1:0] result_out
);

    // ************************************************************
    // step logic
    // ************************************************************

    // saturate instead of wrapping so a runaway host cannot jump ends
    always_comb begin
        result_out = value_in;
        unique case (cmd_in)
            dwn_pkg::DWN_CMD_INC: begin
                if (value_in != {W{1'b1}}) begin
                    result_out = value_in + {{(W-1){1'b0}}, 1'b1};
                end
            end
            dwn_pkg::DWN_CMD_DEC: begin
                if (value_in != {W{1'b0}}) begin
                    result_out = value_in - {{(W-1){1'b0}}, 1'b1};
                end
            end
            dwn_pkg::DWN_CMD_SHL: begin
                // doubling; top bit set means it would overflow
                if (value_in[W-1]) begin
                    result_out = {W{1'b1}};
                end else begin
                    result_out = {value_in[W-2:0], 1'b0};
                end
            end
            dwn_pkg::DWN_CMD_SHR: begin
                result_out = {1'b0, value_in[W-1:1]};
            end
            default: begin
                result_out = value_in;
            end
        endcase
    end

endmodule

`default_nettype wire

/* File: include/dwn_pkg.sv */
/*
 * shared constants for the dual wiper nonvolatile control block:
 * command codes, register select codes, reset values and sizes.
 * assumes the command port is driven by logic synchronous to core_clk_in.
 */
`default_nettype none

package dwn_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned USER_BYTES = 14;
    localparam int unsigned SEL_W      = 4;

    // ************************************************************
    // commands
    // ************************************************************
    typedef enum logic [3:0] {
        DWN_CMD_NOP     = 4'h0,
        DWN_CMD_LOAD    = 4'h1,
        DWN_CMD_RESTORE = 4'h2,
        DWN_CMD_SAVE    = 4'h3,
        DWN_CMD_INC     = 4'h4,
        DWN_CMD_DEC     = 4'h5,
        DWN_CMD_SHL     = 4'h6,
        DWN_CMD_SHR     = 4'h7,
        DWN_CMD_USER_WR = 4'h8,
        DWN_CMD_READ    = 4'h9,
        DWN_CMD_PROTECT = 4'ha
    } dwn_cmd_t;

    // ************************************************************
    // read select codes
    // ************************************************************
    localparam logic [1:0] RD_WIPER  = 2'h0;
    localparam logic [1:0] RD_BACKUP = 2'h1;
    localparam logic [1:0] RD_USER   = 2'h2;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] WIPER_RST  = 8'h80;
    localparam logic [7:0] BACKUP_RST = 8'h80;
    localparam logic [7:0] USER_RST   = 8'h00;

    // ************************************************************
    // timing: cycles for the power-on preset strobe to fire
    // ************************************************************
    localparam int unsigned PRESET_DELAY_NS = 100;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned PRESET_CYCLES   =
        (PRESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

`default_nettype wire

/* File: sim/dwn_control_props.sv */
/*
 * port assertions for dwn_control, attached by the bind at the foot.
 * assumes one clock domain and the reset released at a clock edge.
 */
`default_nettype none
`timescale 1ns/1ps

module dwn_control_props #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input wire logic              core_clk_in,
    input wire logic              rst_n_in,
    // command side
    input wire logic              cmd_valid_in,
    input wire dwn_pkg::dwn_cmd_t cmd_in,
    input wire logic              cmd_ch_in,
    input wire logic [W-1:0]      cmd_data_in,
    input wire logic              preset_n_in,
    // answers
    input wire logic [W-1:0]      wiper_setting_ch1_out,
    input wire logic [W-1:0]      wiper_setting_ch2_out,
    input wire logic              rd_valid_out,
    input wire logic              protected_out,
    input wire logic              refused_out,
    input wire logic              busy_out
);
    default clocking dc @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic [W-1:0] w1;
    logic [W-1:0] w2;
    logic         take;
    logic         fire;
    logic         ok;
    logic         pre_ff;
    logic [4:0]   busy_cnt_ff;

    // a preset fire outranks wiper commands, so those checks skip it
    assign w1   = wiper_setting_ch1_out;
    assign w2   = wiper_setting_ch2_out;
    assign take = cmd_valid_in && !busy_out;
    assign fire = !preset_n_in && pre_ff;
    assign ok   = take && !fire;

    // last preset level and length of the power-on wait
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre_ff      <= 1'b1;
            busy_cnt_ff <= 5'h00;
        end else begin
            pre_ff      <= preset_n_in;
            busy_cnt_ff <= busy_out ? busy_cnt_ff + 5'h01 : 5'h00;
        end
    end

    a_load_applies: assert property (ok && cmd_in == dwn_pkg::DWN_CMD_LOAD
        && !cmd_ch_in |=> w1 == $past(cmd_data_in))
        else $error("load did not reach wiper one");
    a_load_other: assert property (ok && cmd_in == dwn_pkg::DWN_CMD_LOAD
        && !cmd_ch_in |=> $stable(w2))
        else $error("load on one channel moved the other");
    a_inc_one: assert property (ok && cmd_in == dwn_pkg::DWN_CMD_INC
        && !cmd_ch_in && w1 != 8'hff |=> w1 == $past(w1) + 8'h01)
        else $error("increment not one step");
    a_dec_one: assert property (ok && cmd_in == dwn_pkg::DWN_CMD_DEC
        && !cmd_ch_in && w1 != 8'h00 |=> w1 == $past(w1) - 8'h01)
        else $error("decrement not one step");
    a_step_sat: assert property (ok && !cmd_ch_in &&
        ((cmd_in == dwn_pkg::DWN_CMD_INC && w1 == 8'hff) ||
        (cmd_in == dwn_pkg::DWN_CMD_DEC && w1 == 8'h00)) |=> $stable(w1))
        else $error("step wrapped at an end");
    a_shift_up: assert property (ok && cmd_in == dwn_pkg::DWN_CMD_SHL
        && cmd_ch_in |=> w2 == (($past(w2) >= 8'h80) ? 8'hff
        : 8'($past(w2) << 1))) else $error("left shift wrong");
    a_shift_down: assert property (ok && cmd_in == dwn_pkg::DWN_CMD_SHR
        && cmd_ch_in |=> w2 == ($past(w2) >> 1))
        else $error("right shift wrong");
    a_read_answer: assert property (take &&
        cmd_in == dwn_pkg::DWN_CMD_READ |=> rd_valid_out)
        else $error("read gave no answer");
    a_read_cause: assert property (rd_valid_out |-> $past(cmd_valid_in)
        && $past(cmd_in) == dwn_pkg::DWN_CMD_READ)
        else $error("read answer without a read");
    a_refuse_save: assert property (take && protected_out &&
        cmd_in == dwn_pkg::DWN_CMD_SAVE |=> refused_out)
        else $error("protected save not refused");
    a_protect_sets: assert property (take &&
        cmd_in == dwn_pkg::DWN_CMD_PROTECT |=> protected_out [*2])
        else $error("protection not set or not kept");
    a_idle_hold: assert property (!busy_out && !cmd_valid_in && !fire
        |=> $stable(w1) && $stable(w2)) else $error("wiper moved idle");
    a_boot_bound: assert property (busy_cnt_ff < 5'h0d)
        else $error("power-on wait too long");
endmodule

bind dwn_control dwn_control_props #(.W(W)) u_props (
    .core_clk_in           (core_clk_in),
    .rst_n_in              (rst_n_in),
    .cmd_valid_in          (cmd_valid_in),
    .cmd_in                (cmd_in),
    .cmd_ch_in             (cmd_ch_in),
    .cmd_data_in           (cmd_data_in),
    .preset_n_in           (preset_n_in),
    .wiper_setting_ch1_out (wiper_setting_ch1_out),
    .wiper_setting_ch2_out (wiper_setting_ch2_out),
    .rd_valid_out          (rd_valid_out),
    .protected_out         (protected_out),
    .refused_out           (refused_out),
    .busy_out              (busy_out)
);

`default_nettype wire

/* File: sim/dwn_host_model.sv */
/*
 * host side model: drives the command port and the preset pin.
 * assumes its tasks are called from one bench process at a time.
 */
`default_nettype none
`timescale 1ns/1ps

module dwn_host_model (
    // clock and status
    input  wire logic         clk_in,
    input  wire logic         busy_in,
    // command port
    output logic              valid_out,
    output dwn_pkg::dwn_cmd_t cmd_out,
    output logic              ch_out,
    output logic [1:0]        kind_out,
    output logic [3:0]        addr_out,
    output logic [7:0]        data_out,
    // preset strobe, active low
    output logic              preset_n_out
);
    initial begin
        valid_out    = 1'b0;
        cmd_out      = dwn_pkg::DWN_CMD_NOP;
        ch_out       = 1'b0;
        kind_out     = 2'h0;
        addr_out     = 4'h0;
        data_out     = 8'h00;
        preset_n_out = 1'b1;
    end

    // one command for one cycle; fields go stale after the taking edge
    task automatic send(input dwn_pkg::dwn_cmd_t c, input logic h,
        input logic [1:0] k, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (busy_in === 1'b1 && n < 64) begin
            @(posedge clk_in);
            n++;
        end
        @(posedge clk_in);
        valid_out <= 1'b1;
        cmd_out   <= c;
        ch_out    <= h;
        kind_out  <= k;
        addr_out  <= a;
        data_out  <= d;
        @(posedge clk_in);
        valid_out <= 1'b0;
        addr_out  <= ~a; // stale fields must never look usable
        data_out  <= ~d;
    endtask

    // low for one edge only, so the next fire needs no extra gap
    task automatic pulse_preset();
        @(posedge clk_in);
        preset_n_out <= 1'b0;
        @(posedge clk_in);
        preset_n_out <= 1'b1;
    endtask
endmodule

`default_nettype wire

/* File: sim/testbench.sv */
/*
 * self-checking bench for dwn_control with the host model in front.
 * assumes the checker is attached by its own bind.
 */
`default_nettype none
`timescale 1ns/1ps

module testbench;
    logic              core_clk;
    logic              rst_n;
    logic              busy;
    logic              valid;
    dwn_pkg::dwn_cmd_t cmd;
    logic              ch;
    logic [1:0]        kind;
    logic [3:0]        addr;
    logic [7:0]        data;
    logic              preset_n;
    logic [7:0]        w1;
    logic [7:0]        w2;
    logic              rd_valid;
    logic [7:0]        rd_data;
    logic              prot;
    logic              refused;
    int                bad_count;
    int                checked;

    dwn_host_model host (.clk_in(core_clk), .busy_in(busy),
        .valid_out(valid), .cmd_out(cmd), .ch_out(ch), .kind_out(kind),
        .addr_out(addr), .data_out(data), .preset_n_out(preset_n));

    dwn_control uut (.core_clk_in(core_clk), .rst_n_in(rst_n),
        .cmd_valid_in(valid), .cmd_in(cmd), .cmd_ch_in(ch),
        .rd_kind_in(kind), .cmd_addr_in(addr), .cmd_data_in(data),
        .preset_n_in(preset_n), .wiper_setting_ch1_out(w1),
        .wiper_setting_ch2_out(w2), .rd_valid_out(rd_valid),
        .rd_data_out(rd_data), .protected_out(prot),
        .refused_out(refused), .busy_out(busy));

    // ****************************************
    // clock, checks and verdict
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic op(dwn_pkg::dwn_cmd_t c, logic h, logic [1:0] k,
        logic [3:0] a, logic [7:0] d);
        host.send(c, h, k, a, d);
        #1;
    endtask

    task automatic rd(logic [1:0] k, logic h, logic [3:0] a, logic [7:0] e);
        op(dwn_pkg::DWN_CMD_READ, h, k, a, 8'h00);
        chk({7'h00, rd_valid}, 8'h01);
        chk(rd_data, e);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // power-on wait, then wipers equal the reset backups
    task automatic do_reset();
        int n;
        n = 0;
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        while (busy === 1'b1 && n < 30) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk({7'h00, n >= 10 && n <= 12}, 8'h01);
        chk(w1, 8'h80);
        chk(w2, 8'h80);
        chk({7'h00, prot}, 8'h00);
    endtask

    task automatic t_load();
        op(dwn_pkg::DWN_CMD_LOAD, 1'b0, 2'h0, 4'h0, 8'h33);
        op(dwn_pkg::DWN_CMD_LOAD, 1'b1, 2'h0, 4'h0, 8'hcc);
        chk(w1, 8'h33);
        chk(w2, 8'hcc);
        rd(dwn_pkg::RD_WIPER, 1'b0, 4'h0, 8'h33);
        rd(dwn_pkg::RD_WIPER, 1'b1, 4'h0, 8'hcc);
    endtask

    // steps at both ends of the range
    task automatic t_step();
        op(dwn_pkg::DWN_CMD_LOAD, 1'b0, 2'h0, 4'h0, 8'hfe);
        op(dwn_pkg::DWN_CMD_INC, 1'b0, 2'h0, 4'h0, 8'h00);
        chk(w1, 8'hff);
        op(dwn_pkg::DWN_CMD_INC, 1'b0, 2'h0, 4'h0, 8'h00);
        chk(w1, 8'hff);
        op(dwn_pkg::DWN_CMD_LOAD, 1'b0, 2'h0, 4'h0, 8'h01);
        op(dwn_pkg::DWN_CMD_DEC, 1'b0, 2'h0, 4'h0, 8'h00);
        chk(w1, 8'h00);
        op(dwn_pkg::DWN_CMD_DEC, 1'b0, 2'h0, 4'h0, 8'h00);
        chk(w1, 8'h00);
    endtask

    task automatic t_shift();
        op(dwn_pkg::DWN_CMD_LOAD, 1'b1, 2'h0, 4'h0, 8'h41);
        op(dwn_pkg::DWN_CMD_SHL, 1'b1, 2'h0, 4'h0, 8'h00);
        chk(w2, 8'h82);
        op(dwn_pkg::DWN_CMD_SHL, 1'b1, 2'h0, 4'h0, 8'h00);
        chk(w2, 8'hff);
        op(dwn_pkg::DWN_CMD_SHR, 1'b1, 2'h0, 4'h0, 8'h00);
        chk(w2, 8'h7f);
    endtask

    // save, restore and the external preset
    task automatic t_nv();
        op(dwn_pkg::DWN_CMD_LOAD, 1'b0, 2'h0, 4'h0, 8'h5a);
        op(dwn_pkg::DWN_CMD_SAVE, 1'b0, 2'h0, 4'h0, 8'h00);
        op(dwn_pkg::DWN_CMD_LOAD, 1'b0, 2'h0, 4'h0, 8'h00);
        rd(dwn_pkg::RD_BACKUP, 1'b0, 4'h0, 8'h5a);
        op(dwn_pkg::DWN_CMD_RESTORE, 1'b0, 2'h0, 4'h0, 8'h00);
        chk(w1, 8'h5a);
        op(dwn_pkg::DWN_CMD_LOAD, 1'b1, 2'h0, 4'h0, 8'h77);
        op(dwn_pkg::DWN_CMD_SAVE, 1'b1, 2'h0, 4'h0, 8'h00);
        op(dwn_pkg::DWN_CMD_LOAD, 1'b1, 2'h0, 4'h0, 8'h11);
        op(dwn_pkg::DWN_CMD_LOAD, 1'b0, 2'h0, 4'h0, 8'h22);
        host.pulse_preset();
        #1;
        chk(w1, 8'h5a);
        chk(w2, 8'h77);
    endtask

    task automatic t_user();
        for (int i = 0; i < 14; i++) begin
            op(dwn_pkg::DWN_CMD_USER_WR, 1'b0, 2'h0, 4'(i), 8'(8'ha0 + i));
        end
        for (int i = 0; i < 14; i++) begin
            rd(dwn_pkg::RD_USER, 1'b0, 4'(i), 8'(8'ha0 + i));
        end
        rd(dwn_pkg::RD_USER, 1'b0, 4'he, 8'h00);
        rd(2'h3, 1'b0, 4'h0, 8'h00);
    endtask

    // protected stores refuse, wipers stay adjustable
    task automatic t_protect();
        op(dwn_pkg::DWN_CMD_PROTECT, 1'b0, 2'h0, 4'h0, 8'h00);
        chk({7'h00, prot}, 8'h01);
        op(dwn_pkg::DWN_CMD_LOAD, 1'b0, 2'h0, 4'h0, 8'h03);
        op(dwn_pkg::DWN_CMD_SAVE, 1'b0, 2'h0, 4'h0, 8'h00);
        chk({7'h00, refused}, 8'h01);
        chk(w1, 8'h03);
        op(dwn_pkg::DWN_CMD_USER_WR, 1'b0, 2'h0, 4'h0, 8'h55);
        chk({7'h00, refused}, 8'h01);
        rd(dwn_pkg::RD_BACKUP, 1'b0, 4'h0, 8'h5a);
        rd(dwn_pkg::RD_USER, 1'b0, 4'h0, 8'ha0);
    endtask

    initial begin
        #100000;
        bad_count++;
        $display("unexpected at %0t: run did not finish", $time);
        summarize();
    end

    initial begin
        bad_count = 0;
        checked   = 0;
        rst_n     = 1'b0;
        do_reset();
        t_load();
        t_step();
        t_shift();
        t_nv();
        t_user();
        t_protect();
        do_reset();
        summarize();
    end
endmodule

`default_nettype wire
